// file: design/cc16_pkg.sv
package cc16_pkg;

   localparam int DATA_W     = 8;
   localparam int ADDR_W     = 8;
   localparam int CNT_W      = 16;
   localparam int NUM_CH     = 2;
   localparam int FILTER_LEN = 4;

   localparam logic [ADDR_W-1:0] REG_CTRL_A   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CTRL_B   = 8'h01;
   localparam logic [ADDR_W-1:0] REG_FORCE    = 8'h02;
   localparam logic [ADDR_W-1:0] REG_CMP_STAT = 8'h03;
   localparam logic [ADDR_W-1:0] REG_FLAGS    = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 8'h05;
   localparam logic [ADDR_W-1:0] REG_CAP_L    = 8'h06;
   localparam logic [ADDR_W-1:0] REG_CAP_H    = 8'h07;
   localparam logic [ADDR_W-1:0] REG_CMPA_L   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CMPA_H   = 8'h09;
   localparam logic [ADDR_W-1:0] REG_CMPB_L   = 8'h0A;
   localparam logic [ADDR_W-1:0] REG_CMPB_H   = 8'h0B;

   // Control A: mode A [7:6], mode B [5:4], waveform [1:0]
   localparam int CTA_COM_HI   = 7;
   localparam int CTA_WGM_LO   = 0;
   // Control B: filter [7], rising edge [6], waveform [4:3]
   localparam int CTB_FILT     = 7;
   localparam int CTB_EDGE     = 6;
   localparam int CTB_WGM_LO   = 3;
   localparam int FORCE_A_BIT  = 7;
   localparam int CSTAT_SEL    = 2;
   localparam int FLG_CAP      = 5;
   localparam int FLG_CMP_LO   = 1;

   localparam logic [DATA_W-1:0] CTRL_A_RST = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_B_RST = 8'h00;
   localparam logic [CNT_W-1:0]  TOP_8BIT   = 16'h00FF;
   localparam logic [CNT_W-1:0]  TOP_9BIT   = 16'h01FF;
   localparam logic [CNT_W-1:0]  TOP_10BIT  = 16'h03FF;
   localparam logic [CNT_W-1:0]  TOP_MAX    = 16'hFFFF;

   typedef enum logic [3:0] {
      WGM_NORMAL  = 4'h0, WGM_PC8   = 4'h1, WGM_PC9   = 4'h2, WGM_PC10  = 4'h3,
      WGM_CTC_A   = 4'h4, WGM_FAST8 = 4'h5, WGM_FAST9 = 4'h6, WGM_FAST10 = 4'h7,
      WGM_PFC_CAP = 4'h8, WGM_PFC_A = 4'h9, WGM_PC_CAP = 4'hA, WGM_PC_A  = 4'hB,
      WGM_CTC_CAP = 4'hC, WGM_RSVD  = 4'hD, WGM_FAST_CAP = 4'hE, WGM_FAST_A = 4'hF
   } wgm_t;

   typedef enum logic [1:0] {
      COM_OFF = 2'h0, COM_TOGGLE = 2'h1, COM_CLEAR = 2'h2, COM_SET = 2'h3
   } com_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

   typedef struct packed {
      logic [CNT_W-1:0] value;
      logic             tick;
      logic             at_top;
      logic             at_bottom;
      logic             down;
      logic             write;
   } counter_t;

   function automatic logic is_pwm(input wgm_t w);
      return !(w == WGM_NORMAL || w == WGM_CTC_A || w == WGM_CTC_CAP || w == WGM_RSVD);
   endfunction

   function automatic logic cap_is_top(input wgm_t w);
      return w == WGM_PFC_CAP || w == WGM_PC_CAP || w == WGM_CTC_CAP || w == WGM_FAST_CAP;
   endfunction

   function automatic logic is_fast(input wgm_t w);
      return w == WGM_FAST8 || w == WGM_FAST9 || w == WGM_FAST10 || w == WGM_FAST_CAP || w == WGM_FAST_A;
   endfunction

endpackage

// file: design/cc16_unit.sv
// Decided for this implementation: strobed register access and the register addresses.
module cc16_unit
   import cc16_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Register port
   input  wire bus_req_t           bus,
   output logic [DATA_W-1:0]       rdata_ff,
   // Trigger inputs from pins
   input  wire logic               capture_pin,
   input  wire logic               comparator_output,
   // Counter unit status
   input  wire counter_t           cnt,
   // Interrupt service acknowledges
   input  wire logic               capture_ack,
   input  wire logic [NUM_CH-1:0]  compare_ack,
   // Results
   output logic                    capture_irq_ff,
   output logic [NUM_CH-1:0]       compare_irq_ff,
   output logic [NUM_CH-1:0]       compare_output_state_ff,
   output logic [CNT_W-1:0]        top_value_ff
);

   logic [DATA_W-1:0]     ctrl_a_ff, nxt_ctrl_a, ctrl_b_ff, nxt_ctrl_b;
   logic                  comp_sel_ff, nxt_comp_sel;
   logic [DATA_W-1:0]     irq_en_ff, nxt_irq_en, temp_ff, nxt_temp, nxt_rdata;
   logic [CNT_W-1:0]      cap_ff, nxt_cap;
   logic                  cap_flag_ff, nxt_cap_flag;
   logic [CNT_W-1:0]      cmp_ff [NUM_CH], nxt_cmp [NUM_CH];
   logic [CNT_W-1:0]      buf_ff [NUM_CH], nxt_buf [NUM_CH];
   logic [NUM_CH-1:0]     cflag_ff, nxt_cflag, nxt_oc, match, cmp_set;
   logic                  block_ff, nxt_block;
   logic                  pin_s1_ff, pin_s2_ff, cmp_s1_ff, cmp_s2_ff;
   logic [FILTER_LEN-1:0] shift_ff, nxt_shift;
   logic                  filt_ff, nxt_filt, prev_ff, nxt_prev;
   logic                  cap_src, filt_out, cap_trig, edge_ok;
   logic                  nxt_cap_irq;
   logic [NUM_CH-1:0]     nxt_cmp_irq;
   logic [CNT_W-1:0]      nxt_top;
   wgm_t                  wgm;
   logic                  filt_en, pwm, wr_force;

   function automatic com_t com_of(input logic [DATA_W-1:0] ca, input int ch);
      return com_t'(ca[CTA_COM_HI-2*ch -: 2]);
   endfunction

   // Output action for a match; phase correct modes depend on direction
   function automatic logic match_action(input com_t c, input wgm_t w, input logic down, input logic cur);
      logic r;
      r = cur;
      if (!is_pwm(w)) begin
         unique case (c)
            COM_TOGGLE: r = !cur;
            COM_CLEAR:  r = 1'b0;
            COM_SET:    r = 1'b1;
            COM_OFF:    r = cur;
         endcase
      end else if (c == COM_CLEAR) begin
         r = is_fast(w) ? 1'b0 : down;
      end else if (c == COM_SET) begin
         r = is_fast(w) ? 1'b1 : !down;
      end
      return r;
   endfunction

   assign wgm      = wgm_t'({ctrl_b_ff[CTB_WGM_LO +: 2], ctrl_a_ff[CTA_WGM_LO +: 2]});
   assign filt_en  = ctrl_b_ff[CTB_FILT];
   assign pwm      = is_pwm(wgm);
   assign wr_force = bus.wr && bus.addr == REG_FORCE;

   // Two-flop synchronizers for the capture pin and the comparator output
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         cmp_s1_ff <= 1'b0;
         cmp_s2_ff <= 1'b0;
      end else begin
         pin_s1_ff <= capture_pin;
         pin_s2_ff <= pin_s1_ff;
         cmp_s1_ff <= comparator_output;
         cmp_s2_ff <= cmp_s1_ff;
      end
   end

   // Capture path: source select, filter, edge detector
   assign cap_src  = comp_sel_ff ? cmp_s2_ff : pin_s2_ff;
   assign filt_out = filt_en ? filt_ff : cap_src;
   assign edge_ok  = ctrl_b_ff[CTB_EDGE] ? filt_out : !filt_out;
   assign cap_trig = (filt_out != prev_ff) && edge_ok && !cap_is_top(wgm);

   always_comb begin
      nxt_shift = {shift_ff[FILTER_LEN-2:0], cap_src};
      nxt_filt  = filt_ff;
      // Judging the incoming sample too keeps the added delay at four clocks
      if (nxt_shift == {FILTER_LEN{1'b1}}) begin
         nxt_filt = 1'b1;
      end else if (nxt_shift == {FILTER_LEN{1'b0}}) begin
         nxt_filt = 1'b0;
      end
      // Detector stays frozen in capture-top modes, so a level change there fires an edge on leaving
      nxt_prev = cap_is_top(wgm) ? prev_ff : filt_out;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shift_ff <= '0;
         filt_ff  <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         shift_ff <= nxt_shift;
         filt_ff  <= nxt_filt;
         prev_ff  <= nxt_prev;
      end
   end

   // Comparators run continuously
   always_comb begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
         match[ch]   = cnt.value == cmp_ff[ch];
         cmp_set[ch] = cnt.tick && match[ch] && !block_ff;
      end
   end

   // Registers, flags, compare values and output state
   always_comb begin
      nxt_ctrl_a   = ctrl_a_ff;
      nxt_ctrl_b   = ctrl_b_ff;
      nxt_comp_sel = comp_sel_ff;
      nxt_irq_en   = irq_en_ff;
      nxt_temp     = temp_ff;
      nxt_cap      = cap_ff;
      nxt_cap_flag = cap_flag_ff;
      nxt_cflag    = cflag_ff;
      nxt_oc       = compare_output_state_ff;
      nxt_rdata    = '0;
      // A counter write blocks matches until the next timer tick has passed
      nxt_block    = cnt.write ? 1'b1 : (cnt.tick ? 1'b0 : block_ff);
      for (int ch = 0; ch < NUM_CH; ch++) begin
         nxt_cmp[ch] = cmp_ff[ch];
         nxt_buf[ch] = buf_ff[ch];
      end

      if (bus.wr) begin
         unique case (bus.addr)
            REG_CTRL_A:   nxt_ctrl_a = bus.wdata;
            REG_CTRL_B:   nxt_ctrl_b = bus.wdata;
            REG_CMP_STAT: nxt_comp_sel = bus.wdata[CSTAT_SEL];
            REG_IRQ_EN:   nxt_irq_en = bus.wdata;
            REG_FLAGS: begin
               nxt_cap_flag = cap_flag_ff && !bus.wdata[FLG_CAP];
               nxt_cflag    = cflag_ff & ~bus.wdata[FLG_CMP_LO +: NUM_CH];
            end
            REG_CAP_H, REG_CMPA_H, REG_CMPB_H: nxt_temp = bus.wdata;
            REG_CAP_L: begin
               if (cap_is_top(wgm)) begin
                  nxt_cap = {temp_ff, bus.wdata};
               end
            end
            REG_CMPA_L, REG_CMPB_L: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (bus.addr == REG_CMPA_L + ADDR_W'(2*ch)) begin
                     if (pwm) begin
                        nxt_buf[ch] = {temp_ff, bus.wdata};
                     end else begin
                        nxt_cmp[ch] = {temp_ff, bus.wdata};
                     end
                  end
               end
            end
            default: ;
         endcase
      end

      if (capture_ack) begin
         nxt_cap_flag = 1'b0;
      end
      nxt_cflag = nxt_cflag & ~compare_ack;
      if (cap_trig) begin
         nxt_cap      = cnt.value;
         nxt_cap_flag = 1'b1;
      end

      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (cmp_set[ch]) begin
            nxt_cflag[ch] = 1'b1;
            nxt_oc[ch] = match_action(com_of(ctrl_a_ff, ch), wgm, cnt.down,
                                      compare_output_state_ff[ch]);
         end
         // Force: same output action as a match, flag and counter untouched
         if (wr_force && bus.wdata[FORCE_A_BIT-ch] && !pwm) begin
            nxt_oc[ch] = match_action(com_of(ctrl_a_ff, ch), wgm, cnt.down,
                                      compare_output_state_ff[ch]);
         end
         // Fast modes restart the pulse at bottom
         if (pwm && is_fast(wgm) && cnt.tick && cnt.at_bottom) begin
            if (com_of(ctrl_a_ff, ch) == COM_CLEAR) begin
               nxt_oc[ch] = 1'b1;
            end else if (com_of(ctrl_a_ff, ch) == COM_SET) begin
               nxt_oc[ch] = 1'b0;
            end
         end
         // Buffered value moves over at bottom for the frequency correct modes
         if (pwm && cnt.tick && ((wgm == WGM_PFC_CAP || wgm == WGM_PFC_A) ? cnt.at_bottom : cnt.at_top)) begin
            nxt_cmp[ch] = buf_ff[ch];
         end
      end

      if (bus.rd) begin
         unique case (bus.addr)
            REG_CTRL_A:   nxt_rdata = ctrl_a_ff;
            REG_CTRL_B:   nxt_rdata = ctrl_b_ff;
            REG_CMP_STAT: nxt_rdata = DATA_W'({comp_sel_ff, {CSTAT_SEL{1'b0}}});
            REG_IRQ_EN:   nxt_rdata = irq_en_ff;
            REG_FLAGS: begin
               nxt_rdata[FLG_CAP] = cap_flag_ff;
               nxt_rdata[FLG_CMP_LO +: NUM_CH] = cflag_ff;
            end
            REG_CAP_L: begin
               nxt_rdata = cap_ff[DATA_W-1:0];
               nxt_temp  = cap_ff[CNT_W-1:DATA_W];
            end
            REG_CAP_H:  nxt_rdata = temp_ff;
            // Compare values change only by writes, so no temp on read
            REG_CMPA_L: nxt_rdata = pwm ? buf_ff[0][DATA_W-1:0] : cmp_ff[0][DATA_W-1:0];
            REG_CMPA_H: nxt_rdata = pwm ? buf_ff[0][CNT_W-1:DATA_W] : cmp_ff[0][CNT_W-1:DATA_W];
            REG_CMPB_L: nxt_rdata = pwm ? buf_ff[1][DATA_W-1:0] : cmp_ff[1][DATA_W-1:0];
            REG_CMPB_H: nxt_rdata = pwm ? buf_ff[1][CNT_W-1:DATA_W] : cmp_ff[1][CNT_W-1:DATA_W];
            default:    nxt_rdata = '0;
         endcase
      end

      nxt_cap_irq = nxt_cap_flag && irq_en_ff[FLG_CAP];
      nxt_cmp_irq = nxt_cflag & irq_en_ff[FLG_CMP_LO +: NUM_CH];

      unique case (wgm)
         WGM_PC8, WGM_FAST8:   nxt_top = TOP_8BIT;
         WGM_PC9, WGM_FAST9:   nxt_top = TOP_9BIT;
         WGM_PC10, WGM_FAST10: nxt_top = TOP_10BIT;
         WGM_CTC_A, WGM_PFC_A, WGM_PC_A, WGM_FAST_A: nxt_top = cmp_ff[0];
         WGM_PFC_CAP, WGM_PC_CAP, WGM_CTC_CAP, WGM_FAST_CAP: nxt_top = cap_ff;
         default:              nxt_top = TOP_MAX;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_a_ff               <= CTRL_A_RST;
         ctrl_b_ff               <= CTRL_B_RST;
         comp_sel_ff             <= 1'b0;
         irq_en_ff               <= '0;
         temp_ff                 <= '0;
         cap_ff                  <= '0;
         cap_flag_ff             <= 1'b0;
         cflag_ff                <= '0;
         block_ff                <= 1'b0;
         compare_output_state_ff <= '0;
         rdata_ff                <= '0;
         capture_irq_ff          <= 1'b0;
         compare_irq_ff          <= '0;
         top_value_ff            <= TOP_MAX;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            cmp_ff[ch] <= '0;
            buf_ff[ch] <= '0;
         end
      end else begin
         ctrl_a_ff               <= nxt_ctrl_a;
         ctrl_b_ff               <= nxt_ctrl_b;
         comp_sel_ff             <= nxt_comp_sel;
         irq_en_ff               <= nxt_irq_en;
         temp_ff                 <= nxt_temp;
         cap_ff                  <= nxt_cap;
         cap_flag_ff             <= nxt_cap_flag;
         cflag_ff                <= nxt_cflag;
         block_ff                <= nxt_block;
         compare_output_state_ff <= nxt_oc;
         rdata_ff                <= nxt_rdata;
         capture_irq_ff          <= nxt_cap_irq;
         compare_irq_ff          <= nxt_cmp_irq;
         top_value_ff            <= nxt_top;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            cmp_ff[ch] <= nxt_cmp[ch];
            buf_ff[ch] <= nxt_buf[ch];
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_CAPTURE_STAMP: assert property (cap_trig |=> cap_flag_ff && cap_ff == $past(cnt.value))
      else $error("capture did not stamp counter and flag together");
   AST_CAPTURE_OVERWRITE: assert property (cap_flag_ff && cap_trig |=> cap_ff == $past(cnt.value))
      else $error("pending capture not overwritten");
   AST_PIN_SOURCE: assert property (!comp_sel_ff && !filt_en && !cap_is_top(wgm) && ctrl_b_ff[CTB_EDGE]
                                    && $rose(pin_s2_ff) && $stable(comp_sel_ff) && !prev_ff |-> cap_trig)
      else $error("rising pin edge missed");
   AST_FILTER_AGREE: assert property ($past(filt_en) && $changed(filt_ff)
                                      |-> shift_ff == {FILTER_LEN{filt_ff}})
      else $error("filter moved without four equal samples");
   AST_FILTER_DELAY: assert property (filt_en && $rose(filt_ff) && ctrl_b_ff[CTB_EDGE]
                                      && !cap_is_top(wgm) && $stable(ctrl_b_ff) && $stable(wgm) |-> cap_trig)
      else $error("filtered edge did not reach the detector");
   AST_TOP_MODE_OFF: assert property (cap_is_top(wgm) |-> !cap_trig)
      else $error("capture in capture-top mode");
   AST_MATCH_FLAG: assert property (cnt.tick && match[0] && !block_ff && !compare_ack[0] |=> cflag_ff[0])
      else $error("match did not set compare flag");
   AST_WRITE_BLOCK: assert property (cnt.write ##1 cnt.tick |-> !cmp_set[0] && !cmp_set[1])
      else $error("match not blocked after counter write");
   AST_DIRECT_LOAD: assert property (bus.wr && bus.addr == REG_CMPA_L && !pwm && !(cnt.tick && cnt.at_top)
                                     |=> cmp_ff[0] == {$past(temp_ff), $past(bus.wdata)})
      else $error("direct compare write not atomic");
   AST_FORCE_CLEAR: assert property (wr_force && bus.wdata[FORCE_A_BIT] && !pwm
                                     && com_of(ctrl_a_ff, 0) == COM_CLEAR
                                     |=> !compare_output_state_ff[0])
      else $error("force did not clear output");
   AST_FLAG_CLEAR: assert property (bus.wr && bus.addr == REG_FLAGS && bus.wdata[FLG_CMP_LO] && !cmp_set[0]
                                    |=> !cflag_ff[0])
      else $error("write one did not clear compare flag");
   AST_BUFFER_LOAD: assert property (pwm && cnt.tick && cnt.at_top
                                     && wgm != WGM_PFC_CAP && wgm != WGM_PFC_A |=> cmp_ff[0] == $past(buf_ff[0]))
      else $error("buffered compare value not loaded at top");
   AST_FORCE_NO_FLAG: assert property (wr_force && !cmp_set[0] && !cflag_ff[0] |=> !cflag_ff[0])
      else $error("force set the compare flag");
   AST_MODE_KEEPS_STATE: assert property (bus.wr && bus.addr == REG_CTRL_B && cmp_set == '0
                                          && !(cnt.tick && cnt.at_bottom)
                                          |=> compare_output_state_ff == $past(compare_output_state_ff))
      else $error("output state changed with waveform mode");
   AST_CMP_READ_NO_TEMP: assert property (bus.rd && !bus.wr
                                          && (bus.addr == REG_CMPA_L || bus.addr == REG_CMPA_H)
                                          |=> temp_ff == $past(temp_ff))
      else $error("compare read disturbed the shared temp");
   AST_CAPTURE_ACK: assert property (capture_ack && !cap_trig |=> !cap_flag_ff)
      else $error("capture service did not clear flag");
   AST_COMPARE_ACK: assert property (compare_ack[0] && !cmp_set[0] |=> !cflag_ff[0])
      else $error("compare service did not clear flag");
   AST_TOP_FROM_A: assert property (wgm == WGM_CTC_A && $stable(wgm) && $stable(cmp_ff[0])
                                    |-> top_value_ff == cmp_ff[0])
      else $error("compare A does not define top");

   COV_FILTERED_CAPTURE: cover property (filt_en && cap_trig);
   COV_FORCE: cover property (wr_force && !pwm);
   COV_BUFFER_LOAD: cover property (pwm && cnt.tick && cnt.at_top);
   COV_BLOCKED: cover property (block_ff && cnt.tick && match[0]);
   COV_COMPARE_MATCH: cover property (cmp_set[0] && !pwm);

endmodule

// file: verification/cc16_counter_model.sv
module cc16_counter_model
   import cc16_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Bench control
   input  wire logic             run,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_value,
   input  wire logic [CNT_W-1:0] top,
   // Counter status towards the unit
   output counter_t              cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic             div_ff;
   logic [CNT_W-1:0] value_ff;
   // One timer tick every second clock, so matches are not hidden by a 1:1 rate
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_ff   <= 1'b0;
         value_ff <= '0;
      end else if (load) begin
         value_ff <= load_value;
      end else begin
         div_ff <= run & ~div_ff;
         if (run && div_ff) begin
            value_ff <= (value_ff == top) ? '0 : value_ff + 16'h0001;
         end
      end
   end
   always_comb begin
      cnt.value     = value_ff;
      cnt.tick      = run & div_ff & ~load;
      cnt.at_top    = (value_ff == top);
      cnt.at_bottom = (value_ff == 16'h0000);
      cnt.down      = 1'b0;
      cnt.write     = load;
   end
endmodule

// file: verification/timer16_capture_compare_units_tb.sv
module timer16_capture_compare_units_tb
   import cc16_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 1'b0;
   logic              rst_n;
   bus_req_t          bus;
   logic [DATA_W-1:0] rdata_ff;
   logic              capture_pin;
   logic              comparator_output;
   counter_t          cnt;
   logic              capture_ack;
   logic [NUM_CH-1:0] compare_ack;
   logic              capture_irq_ff;
   logic [NUM_CH-1:0] compare_irq_ff;
   logic [NUM_CH-1:0] compare_output_state_ff;
   logic [CNT_W-1:0]  top_value_ff;
   logic              run;
   logic              load;
   logic [CNT_W-1:0]  load_value;
   logic [7:0]        lo_b;
   logic [7:0]        hi_b;
   int                mismatches;
   int                checked;
   int                cycles;
   int                lat0;
   int                lat1;
   int                n;

   always #12.5 clk = ~clk;

   cc16_unit i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata_ff(rdata_ff), .capture_pin(capture_pin),
      .comparator_output(comparator_output), .cnt(cnt), .capture_ack(capture_ack), .compare_ack(compare_ack),
      .capture_irq_ff(capture_irq_ff), .compare_irq_ff(compare_irq_ff),
      .compare_output_state_ff(compare_output_state_ff), .top_value_ff(top_value_ff));
   cc16_counter_model i_cnt (.clk(clk), .rst_n(rst_n), .run(run), .load(load), .load_value(load_value),
      .top(top_value_ff), .cnt(cnt));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata_ff;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a, lo_b);
      chk({8'h00, lo_b}, {8'h00, e});
   endtask
   // Low byte first: it loads the shared temp with the high byte
   task automatic cap16(input logic [15:0] e);
      rd(REG_CAP_L, lo_b);
      rd(REG_CAP_H, hi_b);
      chk({hi_b, lo_b}, e);
   endtask
   task automatic ticks(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic ld(input logic [15:0] v);
      @(posedge clk);
      load       <= 1'b1;
      load_value <= v;
      @(posedge clk);
      load <= 1'b0;
   endtask
   task automatic pin(input logic v);
      @(posedge clk);
      capture_pin <= v;
   endtask
   task automatic go(input logic v);
      @(posedge clk);
      run <= v;
   endtask
   task automatic wait_cap(output int k);
      k = 0;
      while (capture_irq_ff !== 1'b1 && k < 40) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   initial begin
      bus = '0;
      capture_pin = 1'b0;
      comparator_output = 1'b0;
      capture_ack = 1'b0;
      compare_ack = '0;
      run = 1'b0;
      load = 1'b0;
      load_value = '0;
      rst_n = 1'b0;
      mismatches = 0;
      checked = 0;
      repeat (19) @(posedge clk);
      #1;
      chk(16'(compare_output_state_ff), 16'h0000);
      chk(top_value_ff, TOP_MAX);
      @(posedge clk);
      rst_n <= 1'b1;
      rchk(REG_CTRL_B, CTRL_B_RST);
      rchk(8'h3F, 8'h00);
      wr(REG_IRQ_EN, 8'h26);
      // Top stays fixed while captures are measured
      wr(REG_CTRL_B, 8'h40);
      ld(16'h1234);
      pin(1'b1);
      wait_cap(lat0);
      chk(16'(lat0 < 40), 16'h0001);
      cap16(16'h1234);
      rchk(REG_FLAGS, 8'h20);
      // Flag left set on purpose: the next capture must still overwrite
      ld(16'hABCD);
      pin(1'b0);
      pin(1'b1);
      ticks(lat0 + 2);
      cap16(16'hABCD);
      wr(REG_FLAGS, 8'h20);
      ticks(2);
      chk(16'(capture_irq_ff), 16'h0000);
      wr(REG_CMP_STAT, 8'h04);
      wr(REG_FLAGS, 8'h20);
      ld(16'h0777);
      pin(1'b0);
      pin(1'b1);
      ticks(lat0 + 2);
      chk(16'(capture_irq_ff), 16'h0000);
      @(posedge clk);
      comparator_output <= 1'b1;
      wait_cap(n);
      cap16(16'h0777);
      @(posedge clk);
      capture_ack <= 1'b1;
      @(posedge clk);
      capture_ack <= 1'b0;
      ticks(2);
      chk(16'(capture_irq_ff), 16'h0000);
      wr(REG_CMP_STAT, 8'h00);
      wr(REG_CTRL_B, 8'h00);
      wr(REG_FLAGS, 8'h20);
      ld(16'h0555);
      pin(1'b0);
      wait_cap(n);
      cap16(16'h0555);
      wr(REG_CTRL_B, 8'hC0);
      wr(REG_FLAGS, 8'h20);
      pin(1'b1);
      ticks(2);
      pin(1'b0);
      ticks(14);
      chk(16'(capture_irq_ff), 16'h0000);
      pin(1'b1);
      wait_cap(lat1);
      chk(16'(lat1 - lat0), 16'h0004);
      wr(REG_CTRL_B, 8'h58);
      pin(1'b0);
      wr(REG_FLAGS, 8'h20);
      pin(1'b1);
      ticks(14);
      chk(16'(capture_irq_ff), 16'h0000);
      $display("Test capture done, mismatches %0d", mismatches);
      wr(REG_CTRL_B, 8'h00);
      wr(REG_CTRL_A, 8'h40);
      wr(REG_FLAGS, 8'h20);
      wr(REG_CMPA_H, 8'h01);
      wr(REG_CMPA_L, 8'h50);
      rchk(REG_CMPA_H, 8'h01);
      rchk(REG_CMPA_L, 8'h50);
      ld(16'h0150);
      go(1'b1);
      ticks(8);
      go(1'b0);
      chk(16'(compare_irq_ff), 16'h0000);
      // Load while running so the write is followed at once by a tick
      go(1'b1);
      ld(16'h0140);
      n = 0;
      while (compare_irq_ff[0] !== 1'b1 && n < 80) begin
         @(posedge clk);
         #1;
         n++;
      end
      go(1'b0);
      chk(16'(n < 80), 16'h0001);
      chk(16'(compare_output_state_ff), 16'h0001);
      rchk(REG_FLAGS, 8'h02);
      @(posedge clk);
      compare_ack <= 2'b01;
      @(posedge clk);
      compare_ack <= 2'b00;
      rchk(REG_FLAGS, 8'h00);
      wr(REG_CTRL_A, 8'h80);
      wr(REG_FORCE, 8'h80);
      ticks(1);
      chk(16'(compare_output_state_ff), 16'h0000);
      wr(REG_CTRL_A, 8'hF0);
      wr(REG_FORCE, 8'hC0);
      ticks(1);
      chk(16'(compare_output_state_ff), 16'h0003);
      rchk(REG_FLAGS, 8'h00);
      wr(REG_CTRL_B, 8'h08);
      ticks(1);
      chk(16'(compare_output_state_ff), 16'h0003);
      // Counter kept below top because in this mode the variable top is written directly
      ld(16'h0000);
      wr(REG_CMPA_H, 8'h00);
      wr(REG_CMPA_L, 8'h10);
      ticks(1);
      chk(top_value_ff, 16'h0010);
      wr(REG_CTRL_A, 8'hF3);
      wr(REG_CTRL_B, 8'h18);
      wr(REG_CMPA_L, 8'h20);
      rchk(REG_CMPA_L, 8'h20);
      chk(top_value_ff, 16'h0010);
      go(1'b1);
      ticks(60);
      go(1'b0);
      chk(top_value_ff, 16'h0020);
      $display("Test compare done, mismatches %0d", mismatches);
      end_of_test();
   end
endmodule
